// [design/tsspi_pkg.sv]
// shared constants and types for the temperature sensor serial slave
package tsspi_pkg;

    // register addresses as carried in the first serial byte
    localparam logic [7:0] ADDR_SETUP_RD = 8'h00;
    localparam logic [7:0] ADDR_TLOW_RD = 8'h01;
    localparam logic [7:0] ADDR_THIGH_RD = 8'h02;
    localparam logic [7:0] ADDR_SETUP_WR = 8'h80;
    localparam int ADDR_WRITE_BIT = 7;

    // serial framing
    localparam int BYTE_BITS = 8;
    localparam int BIT_CNT_W = 3;
    localparam logic [BIT_CNT_W-1:0] BIT_LAST = 3'h7;
    localparam logic [BIT_CNT_W-1:0] BIT_FIRST = 3'h0;

    // resolution codes held in the setup register
    localparam logic [2:0] RES_8B = 3'h0;
    localparam logic [2:0] RES_9B = 3'h1;
    localparam logic [2:0] RES_10B = 3'h2;
    localparam logic [2:0] RES_11B = 3'h3;

    // result masks per resolution; the low four bits are always zero
    localparam logic [15:0] MASK_8B = 16'hff00;
    localparam logic [15:0] MASK_9B = 16'hff80;
    localparam logic [15:0] MASK_10B = 16'hffc0;
    localparam logic [15:0] MASK_11B = 16'hffe0;
    localparam logic [15:0] MASK_12B = 16'hfff0;

    // conversion time doubles with each added resolution bit
    localparam logic [4:0] SHIFT_8B = 5'h00;
    localparam logic [4:0] SHIFT_9B = 5'h01;
    localparam logic [4:0] SHIFT_10B = 5'h02;
    localparam logic [4:0] SHIFT_11B = 5'h03;
    localparam logic [4:0] SHIFT_12B = 5'h04;

    // clock and conversion timing
    localparam int CLK_MHZ = 100;
    localparam int CONV_TIME_8B_US = 75;
    localparam int CONV_CYC_8B = CONV_TIME_8B_US * CLK_MHZ;

    // setup register layout, reserved bits read as zero
    typedef struct packed {
        logic [2:0] rsvd;
        logic one_shot;
        logic [2:0] res;
        logic shutdown;
    } tsspi_setup_t;

    // power-up: 8-bit resolution, powered down
    localparam tsspi_setup_t SETUP_RESET = '{
        rsvd: 3'h0, one_shot: 1'b0, res: RES_8B, shutdown: 1'b1
    };

    // synchronised pin bundle
    typedef struct packed {
        logic mode_sel;
        logic chip_en;
        logic sclk;
        logic serial_in_line;
    } tsspi_pins_t;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ADDR,
        ST_READ,
        ST_WRITE,
        ST_DONE
    } tsspi_state_t;

endpackage

// [design/tsspi_top.sv]
// serial slave, register file and conversion sequencer of the temperature sensor
`timescale 1ns/1ps
module tsspi_top #(
    parameter int unsigned CONV_CYC_8B = tsspi_pkg::CONV_CYC_8B
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // serial pins from the master
    input wire logic SERIAL_INTERFACE_SELECT,
    input wire logic CHIP_ENABLE,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic SERIAL_IN_LINE,
    // serial output pin, enable low while driving
    output logic SERIAL_OUT_LINE,
    output logic SERIAL_OUT_LINE_OE_N,
    // analogue front end sample, signed, degrees times 256
    input wire logic [15:0] TEMP_SAMPLE,
    // status
    output logic CONV_ACTIVE
);

    // two-stage synchroniser for all serial input pins
    tsspi_pkg::tsspi_pins_t pins_q;
    tsspi_pkg::tsspi_pins_t pins_raw;
    logic [$bits(tsspi_pkg::tsspi_pins_t)-1:0] pins_sync;

    assign pins_raw = '{
        mode_sel: SERIAL_INTERFACE_SELECT,
        chip_en: CHIP_ENABLE,
        sclk: SERIAL_CLOCK_IN,
        serial_in_line: SERIAL_IN_LINE
    };

    tsspi_sync #(
        .WIDTH($bits(tsspi_pkg::tsspi_pins_t))
    ) u_pin_sync (
        .clk(CLK),
        .rst_n(RST_N),
        .d(pins_raw),
        .q(pins_sync)
    );

    assign pins_q = tsspi_pkg::tsspi_pins_t'(pins_sync);

    // edge detection on synchronised pins
    logic sclk_prev_q;
    logic ce_prev_q;
    logic cpol_q;

    tsspi_edge u_sclk_edge (
        .clk(CLK),
        .rst_n(RST_N),
        .level(pins_q.sclk),
        .prev(sclk_prev_q)
    );

    tsspi_edge u_ce_edge (
        .clk(CLK),
        .rst_n(RST_N),
        .level(pins_q.chip_en),
        .prev(ce_prev_q)
    );

    wire link_on = pins_q.chip_en && pins_q.mode_sel;
    wire ce_rise = pins_q.chip_en && !ce_prev_q;
    wire sclk_move = pins_q.sclk != sclk_prev_q;
    // leading edge leaves the idle level, trailing edge returns to it
    wire lead_edge = link_on && sclk_move && (sclk_prev_q == cpol_q);
    wire trail_edge = link_on && sclk_move && (sclk_prev_q != cpol_q);

    // idle level caught at enable; a clock moving within the synchroniser
    // skew of enable would be misread, so the master must hold it steady
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cpol_q <= 1'b0;
        end else if (ce_rise) begin
            cpol_q <= pins_q.sclk;
        end
    end

    // serial engine state
    tsspi_pkg::tsspi_state_t state_q;
    tsspi_pkg::tsspi_state_t state_d;
    logic [tsspi_pkg::BIT_CNT_W-1:0] bit_cnt_q;
    logic [7:0] in_shift_q;
    logic [7:0] out_shift_q;
    logic [7:0] ptr_q;
    logic sdo_q;
    logic [15:0] snap_q;

    tsspi_pkg::tsspi_setup_t setup_q;
    logic [15:0] result_q;

    wire byte_end = trail_edge && (bit_cnt_q == tsspi_pkg::BIT_LAST);
    wire [7:0] in_byte = {in_shift_q[6:0], pins_q.serial_in_line};
    wire addr_is_write = in_byte[tsspi_pkg::ADDR_WRITE_BIT];
    wire addr_is_setup_wr = in_byte == tsspi_pkg::ADDR_SETUP_WR;
    wire setup_wr = (state_q == tsspi_pkg::ST_WRITE) && byte_end;

    // read data selection from the current pointer
    logic [7:0] rd_byte;
    always_comb begin
        unique case (ptr_q)
            tsspi_pkg::ADDR_SETUP_RD: rd_byte = setup_q;
            tsspi_pkg::ADDR_TLOW_RD: rd_byte = snap_q[7:0];
            tsspi_pkg::ADDR_THIGH_RD: rd_byte = snap_q[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    // state sequencing
    always_comb begin
        state_d = state_q;
        if (!link_on) begin
            state_d = tsspi_pkg::ST_IDLE;
        end else begin
            unique case (state_q)
                tsspi_pkg::ST_IDLE: begin
                    state_d = tsspi_pkg::ST_ADDR;
                end
                tsspi_pkg::ST_ADDR: begin
                    if (byte_end) begin
                        if (!addr_is_write) begin
                            state_d = tsspi_pkg::ST_READ;
                        end else if (addr_is_setup_wr) begin
                            state_d = tsspi_pkg::ST_WRITE;
                        end else begin
                            state_d = tsspi_pkg::ST_DONE;
                        end
                    end
                end
                tsspi_pkg::ST_READ: begin
                    state_d = tsspi_pkg::ST_READ;
                end
                tsspi_pkg::ST_WRITE: begin
                    if (byte_end) begin
                        state_d = tsspi_pkg::ST_DONE;
                    end
                end
                tsspi_pkg::ST_DONE: begin
                    state_d = tsspi_pkg::ST_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            state_q <= tsspi_pkg::ST_IDLE;
        end else begin
            state_q <= state_d;
        end
    end

    // bit counter and input shifter, capture on trailing edges
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            bit_cnt_q <= tsspi_pkg::BIT_FIRST;
            in_shift_q <= 8'h00;
        end else if (!link_on) begin
            bit_cnt_q <= tsspi_pkg::BIT_FIRST;
            in_shift_q <= 8'h00;
        end else if (trail_edge) begin
            bit_cnt_q <= bit_cnt_q + 3'h1;
            in_shift_q <= in_byte;
        end
    end

    // address pointer: loaded by the address byte, then one step per byte read
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ptr_q <= 8'h00;
        end else if (state_q == tsspi_pkg::ST_ADDR && byte_end) begin
            ptr_q <= in_byte;
        end else if (state_q == tsspi_pkg::ST_READ && byte_end) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // the word is frozen when the address completes so that both bytes of
    // one transfer belong to the same conversion
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            snap_q <= 16'h0000;
        end else if (state_q == tsspi_pkg::ST_ADDR && byte_end) begin
            snap_q <= result_q;
        end
    end

    // output shifter, launch on leading edges; input ignored while reading
    wire first_bit = bit_cnt_q == tsspi_pkg::BIT_FIRST;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            out_shift_q <= 8'h00;
            sdo_q <= 1'b0;
        end else if (state_q == tsspi_pkg::ST_READ && lead_edge) begin
            if (first_bit) begin
                sdo_q <= rd_byte[7];
                out_shift_q <= {rd_byte[6:0], 1'b0};
            end else begin
                sdo_q <= out_shift_q[7];
                out_shift_q <= {out_shift_q[6:0], 1'b0};
            end
        end
    end

    // released in address, write and every idle phase
    assign SERIAL_OUT_LINE = sdo_q;
    assign SERIAL_OUT_LINE_OE_N = !(link_on && state_q == tsspi_pkg::ST_READ);

    // resolution decode
    logic [15:0] res_mask;
    logic [4:0] res_shift;
    always_comb begin
        unique case (setup_q.res)
            tsspi_pkg::RES_8B: begin
                res_mask = tsspi_pkg::MASK_8B;
                res_shift = tsspi_pkg::SHIFT_8B;
            end
            tsspi_pkg::RES_9B: begin
                res_mask = tsspi_pkg::MASK_9B;
                res_shift = tsspi_pkg::SHIFT_9B;
            end
            tsspi_pkg::RES_10B: begin
                res_mask = tsspi_pkg::MASK_10B;
                res_shift = tsspi_pkg::SHIFT_10B;
            end
            tsspi_pkg::RES_11B: begin
                res_mask = tsspi_pkg::MASK_11B;
                res_shift = tsspi_pkg::SHIFT_11B;
            end
            default: begin
                res_mask = tsspi_pkg::MASK_12B;
                res_shift = tsspi_pkg::SHIFT_12B;
            end
        endcase
    end

    // conversion sequencer
    logic conv_busy_q;
    logic [31:0] conv_cnt_q;
    wire [31:0] conv_len = 32'(CONV_CYC_8B) << res_shift;
    wire conv_done = conv_busy_q && (conv_cnt_q == 32'h0000_0000);
    wire conv_req = !setup_q.shutdown || setup_q.one_shot;
    wire conv_start = !conv_busy_q && conv_req;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            conv_busy_q <= 1'b0;
            conv_cnt_q <= 32'h0000_0000;
        end else if (conv_start) begin
            conv_busy_q <= 1'b1;
            conv_cnt_q <= conv_len - 32'h0000_0001;
        end else if (conv_done) begin
            conv_busy_q <= 1'b0;
        end else if (conv_busy_q) begin
            conv_cnt_q <= conv_cnt_q - 32'h0000_0001;
        end
    end

    // masking keeps bits 3:0 clear, so the word stays within 8000..7ff0
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            result_q <= 16'h0000;
        end else if (conv_done) begin
            result_q <= TEMP_SAMPLE & res_mask;
        end
    end

    // setup register; a write landing with a one-shot finish takes priority
    // because it carries the newer intent of software
    wire [7:0] setup_wdata = in_byte;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            setup_q <= tsspi_pkg::SETUP_RESET;
        end else if (setup_wr) begin
            setup_q <= tsspi_pkg::tsspi_setup_t'({3'h0, setup_wdata[4:0]});
        end else if (conv_done && setup_q.shutdown) begin
            setup_q.one_shot <= 1'b0;
        end
    end

    assign CONV_ACTIVE = conv_busy_q;

endmodule

// two-flop synchroniser; only the second stage reads the first, so a
// metastable first stage never reaches the logic
module tsspi_sync #(
    parameter int WIDTH = 1
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // raw pins in, settled levels out
    input wire logic [WIDTH-1:0] d,
    output logic [WIDTH-1:0] q
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] sync_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= d;
            sync_q <= meta_q;
        end
    end

    assign q = sync_q;

endmodule

// one-cycle history of a synchronised level so that its changes show;
// resets low, the idle level of chip enable, so no false rise follows reset
module tsspi_edge (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // level now and one cycle ago
    input wire logic level,
    output logic prev
);

    logic prev_q;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prev_q <= 1'b0;
        end else begin
            prev_q <= level;
        end
    end

    assign prev = prev_q;

endmodule

// [verification/tsspi_monitor.sv]
// concurrent checks on the pins of the temperature sensor serial slave
`timescale 1ns/1ps
module tsspi_monitor #(
    parameter int unsigned CONV_CYC_8B = tsspi_pkg::CONV_CYC_8B
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // serial pins
    input wire logic SERIAL_INTERFACE_SELECT,
    input wire logic CHIP_ENABLE,
    input wire logic SERIAL_CLOCK_IN,
    input wire logic SERIAL_IN_LINE,
    input wire logic SERIAL_OUT_LINE,
    input wire logic SERIAL_OUT_LINE_OE_N,
    // status
    input wire logic CONV_ACTIVE
);
    logic [5:0] edges_q;
    logic sclk_q;
    logic cpol_q;
    logic wr_q;
    logic [3:0] lead_age_q;
    logic [19:0] run_q;
    // raw pin view: the design lags it by its synchronisers, so bounds allow for that
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            edges_q <= 6'h00;
            sclk_q <= 1'b0;
            cpol_q <= 1'b0;
            wr_q <= 1'b0;
            lead_age_q <= 4'hf;
            run_q <= 20'h00000;
        end else begin
            sclk_q <= SERIAL_CLOCK_IN;
            run_q <= CONV_ACTIVE ? run_q + 20'h1 : 20'h0;
            if (lead_age_q != 4'hf) lead_age_q <= lead_age_q + 4'h1;
            if (!CHIP_ENABLE) begin
                edges_q <= 6'h00;
                cpol_q <= SERIAL_CLOCK_IN;
            end else if (SERIAL_CLOCK_IN != sclk_q) begin
                if (edges_q != 6'h3f) edges_q <= edges_q + 6'h1;
                if (edges_q == 6'h01) wr_q <= SERIAL_IN_LINE;
                if (SERIAL_CLOCK_IN != cpol_q) lead_age_q <= 4'h0;
            end
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);
    sequence en_off4; !CHIP_ENABLE [*4]; endsequence
    sequence sel_off4; !SERIAL_INTERFACE_SELECT [*4]; endsequence
    a_idle_released: assert property (en_off4 |-> SERIAL_OUT_LINE_OE_N)
        else $error("output driven while chip enable low");
    a_fall_release: assert property ($fell(CHIP_ENABLE) |-> ##[1:4] SERIAL_OUT_LINE_OE_N)
        else $error("output not released after chip enable fell");
    a_sel_release: assert property (sel_off4 |-> SERIAL_OUT_LINE_OE_N)
        else $error("output driven while interface select low");
    a_addr_hiz: assert property ((CHIP_ENABLE && edges_q < 6'd16) |-> SERIAL_OUT_LINE_OE_N)
        else $error("output driven during address byte");
    a_write_hiz: assert property ((CHIP_ENABLE && wr_q && edges_q >= 6'd2) |-> SERIAL_OUT_LINE_OE_N)
        else $error("output driven in a write frame");
    a_out_leading: assert property ((CHIP_ENABLE && !SERIAL_OUT_LINE_OE_N
        && $past(!SERIAL_OUT_LINE_OE_N) && $changed(SERIAL_OUT_LINE))
        |-> lead_age_q inside {[4'd1:4'd5]})
        else $error("output bit changed away from a leading edge");
    a_reset_quiet: assert property ($rose(RST_N) |-> !CONV_ACTIVE [*8])
        else $error("conversion running after reset");
    a_conv_bounds: assert property ($fell(CONV_ACTIVE)
        |-> (run_q + 2 >= CONV_CYC_8B && run_q <= (CONV_CYC_8B << 4) + 2))
        else $error("conversion length out of range");
endmodule
bind tsspi_top tsspi_monitor #(.CONV_CYC_8B(CONV_CYC_8B)) u_monitor (
    .CLK(CLK),
    .RST_N(RST_N),
    .SERIAL_INTERFACE_SELECT(SERIAL_INTERFACE_SELECT),
    .CHIP_ENABLE(CHIP_ENABLE),
    .SERIAL_CLOCK_IN(SERIAL_CLOCK_IN),
    .SERIAL_IN_LINE(SERIAL_IN_LINE),
    .SERIAL_OUT_LINE(SERIAL_OUT_LINE),
    .SERIAL_OUT_LINE_OE_N(SERIAL_OUT_LINE_OE_N),
    .CONV_ACTIVE(CONV_ACTIVE)
);

// [verification/tsspi_master_model.sv]
// serial bus master model that drives the sensor link
`timescale 1ns/1ps
module tsspi_master_model (
    // bench clock; every pin change falls on its falling edge
    input wire logic clk,
    // link pins
    output logic cen,
    output logic sclk,
    output logic serial_in_line,
    input wire logic serial_out_line,
    input wire logic sdo_oe_n
);
    logic miso;
    // a released line shows the inverse of the last bit, so stale data cannot pass
    assign miso = sdo_oe_n ? ~serial_out_line : serial_out_line;
    initial begin
        cen = 1'b0;
        sclk = 1'b0;
        serial_in_line = 1'b0;
    end
    task automatic frame(input logic cpol, input logic en, input logic [7:0] addr,
                         input logic [23:0] wd, input int nb, output logic [23:0] rd);
        logic [31:0] tx;
        tx = {addr, wd};
        rd = 24'h000000;
        @(negedge clk);
        sclk = cpol;
        repeat (10) @(negedge clk);
        cen = en;
        repeat (10) @(negedge clk);
        // periods of 12 and 13 clocks alternate, 125 ns on average
        for (int i = 0; i < 8 * (nb + 1); i++) begin
            sclk = ~cpol;
            serial_in_line = tx[31 - i];
            repeat (6) @(negedge clk);
            if (i >= 8) rd = {rd[22:0], miso};
            sclk = cpol;
            repeat (6 + i % 2) @(negedge clk);
        end
        repeat (10) @(negedge clk);
        cen = 1'b0;
        serial_in_line = ~serial_in_line;
        repeat (20) @(negedge clk);
    endtask
endmodule

// [verification/tb.sv]
// self-checking bench for the temperature sensor serial slave
`timescale 1ns/1ps
module tb;
    localparam int CONV = 20;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic sel = 1'b1;
    logic [15:0] sample = 16'h0000;
    logic cen, sclk, serial_in_line, serial_out_line, sdo_oe_n, conv_active;
    logic [23:0] rd;
    int miscompares = 0;
    int comparisons = 0;
    int cycles = 0;
    always #5 clk = ~clk;
    tsspi_top #(.CONV_CYC_8B(CONV)) u_dut (.CLK(clk), .RST_N(rst_n),
        .SERIAL_INTERFACE_SELECT(sel), .CHIP_ENABLE(cen), .SERIAL_CLOCK_IN(sclk),
        .SERIAL_IN_LINE(serial_in_line), .SERIAL_OUT_LINE(serial_out_line), .SERIAL_OUT_LINE_OE_N(sdo_oe_n),
        .TEMP_SAMPLE(sample), .CONV_ACTIVE(conv_active));
    tsspi_master_model u_mst (.clk(clk), .cen(cen), .sclk(sclk), .serial_in_line(serial_in_line), .serial_out_line(serial_out_line),
        .sdo_oe_n(sdo_oe_n));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    function automatic logic [15:0] expect_word(input logic [15:0] s, input logic [2:0] res);
        case (res)
            3'h0: return s & 16'hff00;
            3'h1: return s & 16'hff80;
            3'h2: return s & 16'hffc0;
            3'h3: return s & 16'hffe0;
            default: return s & 16'hfff0;
        endcase
    endfunction
    task automatic complete_run();
        $display("comparisons=%0d miscompares=%0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic set_sample(input logic [15:0] s, input int wait_cyc);
        @(negedge clk);
        sample = s;
        repeat (wait_cyc) @(negedge clk);
    endtask
    // hang guard well above the expected run of about 18300 cycles
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            miscompares++;
            complete_run();
        end
    end
    initial begin
        logic [7:0] setup;
        logic [15:0] s;
        void'($urandom(58873));
        repeat (3) @(negedge clk);
        rst_n = 1'b1;
        repeat (3) @(negedge clk);
        check(16'(conv_active), 16'h0000);
        u_mst.frame(1'b0, 1'b1, 8'h00, 24'($urandom), 3, rd);
        check(16'(rd[23:16]), 16'h0001);
        check(rd[15:0], 16'h0000);
        for (int r = 0; r < 5; r++) begin
            setup = {4'h0, 3'(r), 1'b0};
            u_mst.frame(r[0], 1'b1, 8'h80, {setup | (8'($urandom) & 8'he0), 16'h0}, 1, rd);
            u_mst.frame(~r[0], 1'b1, 8'h00, 24'($urandom), 1, rd);
            check(16'(rd[7:0]), 16'(setup));
            for (int k = 0; k < 4; k++) begin
                s = (k == 0) ? 16'h8000 : (k == 1) ? 16'h7ff0 : (k == 2) ? 16'h0100
                    : 16'($urandom) & 16'hfff0;
                set_sample(s, 2 * (CONV << r) + 20);
                u_mst.frame(k[0], 1'b1, 8'h01, 24'($urandom), 2, rd);
                check({rd[7:0], rd[15:8]}, expect_word(s, 3'(r)));
            end
        end
        // enable low, select low, then a write address other than the setup one
        for (int k = 0; k < 3; k++) begin
            @(negedge clk);
            sel = (k != 1);
            u_mst.frame(1'b0, k != 0, (k == 2) ? 8'h81 : 8'h80, 24'h110000, 1, rd);
        end
        @(negedge clk);
        sel = 1'b1;
        u_mst.frame(1'b1, 1'b1, 8'h00, 24'($urandom), 1, rd);
        check(16'(rd[7:0]), 16'h0008);
        set_sample(16'h1ff0, 1);
        u_mst.frame(1'b0, 1'b1, 8'h80, 24'h110000, 1, rd);
        repeat (2 * (CONV << 4) + 60) @(negedge clk);
        check(16'(conv_active), 16'h0000);
        u_mst.frame(1'b0, 1'b1, 8'h00, 24'($urandom), 3, rd);
        check(16'(rd[23:16]), 16'h0001);
        check({rd[7:0], rd[15:8]}, 16'h1f00);
        set_sample(16'h2340, 4 * CONV);
        u_mst.frame(1'b1, 1'b1, 8'h01, 24'($urandom), 3, rd);
        check({rd[15:8], rd[23:16]}, 16'h1f00);
        check(16'(rd[7:0]), 16'h0000);
        complete_run();
    end
endmodule
